// *** mmdia_map.vh ***
// Purpose: register offsets, fields and reset values of the management window
// Assumes: 5-bit register addresses, 16-bit register data
// Notes: included by both design files
`ifndef MMDIA_MAP_VH
`define MMDIA_MAP_VH
`define MMDIA_OFS_PARTNER_NP   5'h08
`define MMDIA_OFS_CONTROL      5'h0D
`define MMDIA_OFS_PORT         5'h0E
`define MMDIA_NP_MORE_BIT      15
`define MMDIA_NP_ACK_BIT       14
`define MMDIA_NP_MSG_BIT       13
`define MMDIA_NP_COMPLY_BIT    12
`define MMDIA_NP_TOGGLE_BIT    11
`define MMDIA_NP_CODE_HI       10
`define MMDIA_NP_CODE_LO       0
`define MMDIA_CTL_MODE_HI      15
`define MMDIA_CTL_MODE_LO      14
`define MMDIA_CTL_RSVD_HI      13
`define MMDIA_CTL_RSVD_LO      5
`define MMDIA_CTL_DEV_HI       4
`define MMDIA_CTL_DEV_LO       0
`define MMDIA_MODE_REG         2'h0
`define MMDIA_MODE_DATA        2'h1
`define MMDIA_MODE_INC_RW      2'h2
`define MMDIA_MODE_INC_WR      2'h3
`define MMDIA_RST_WORD         16'h0000
`define MMDIA_RST_CODE         11'h000
`define MMDIA_RST_DEV          5'h00
`define MMDIA_RST_RSVD         9'h000
`endif

// *** mmdia_addr_store.v ***
// Purpose: per-device stored register address with post-increment
// Assumes: one write or increment per cycle
// Notes: one address word per manageable device
`timescale 1ns/10ps
`include "mmdia_map.vh"
module mmdia_addr_store #(
   parameter DEV_W  = 5,
   parameter DATA_W = 16
) (
   input  wire              clock,
   input  wire              arst_n,
   input  wire [DEV_W-1:0]  dev_sel,
   input  wire              load,
   input  wire [DATA_W-1:0] load_value,
   input  wire              incr,
   output wire [DATA_W-1:0] cur_addr
);
   localparam NDEV = 1 << DEV_W;
   reg [DATA_W-1:0] addr_mem_reg [0:NDEV-1];
   genvar g;
   generate
      for (g = 0; g < NDEV; g = g + 1) begin : g_dev
         always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               addr_mem_reg[g] <= `MMDIA_RST_WORD;
            end else if (dev_sel == g) begin
               if (load) begin
                  addr_mem_reg[g] <= load_value;
               end else if (incr) begin
                  addr_mem_reg[g] <= addr_mem_reg[g] + {{(DATA_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   endgenerate
   assign cur_addr = addr_mem_reg[dev_sel];
endmodule // mmdia_addr_store

// *** mmdia_regs.v ***
// Purpose: partner next-page word and indirect manageable-device access window
// Assumes: management access as one-cycle rd_stb / wr_stb with reg_addr
// Notes: device data reaches an outside store via mmd_* ports; read data is registered and returns the cycle after rd_stb
`timescale 1ns/10ps
`include "mmdia_map.vh"
module mmdia_regs #(
   parameter DEV_W  = 5,
   parameter DATA_W = 16
) (
   input  wire              clock,
   input  wire              arst_n,
   input  wire [4:0]        reg_addr,
   input  wire              rd_stb,
   input  wire              wr_stb,
   input  wire [DATA_W-1:0] wr_data,
   output reg  [DATA_W-1:0] rd_data,
   input  wire              np_valid,
   input  wire              np_more,
   input  wire              np_ack,
   input  wire              np_message,
   input  wire              partner_can_comply,
   input  wire              np_prev_toggle,
   input  wire [10:0]       np_code,
   output reg               mmd_wr,
   output reg               mmd_rd,
   output reg  [DEV_W-1:0]  mmd_dev,
   output reg  [DATA_W-1:0] mmd_addr,
   output reg  [DATA_W-1:0] mmd_wdata,
   input  wire [DATA_W-1:0] mmd_rdata
);
   reg  [DATA_W-1:0] np_word_reg;
   reg  [DATA_W-1:0] np_word_next;
   reg  [1:0]        mode_reg;
   reg  [1:0]        mode_next;
   reg  [8:0]        rsvd_reg;
   reg  [8:0]        rsvd_next;
   reg  [DEV_W-1:0]  dev_reg;
   reg  [DEV_W-1:0]  dev_next;
   reg  [DATA_W-1:0] rd_data_next;
   reg               mmd_wr_next;
   reg               mmd_rd_next;
   reg               load;
   reg               incr;
   wire [DATA_W-1:0] cur_addr;
   wire              np_rd;
   wire              ctl_rd;
   wire              ctl_wr;
   wire              port_rd;
   wire              port_wr;
   wire              data_mode;
   wire [DATA_W-1:0] ctl_word;

   // One address compare, used by every decode
   function is_reg;
      input [4:0] a;
      input [4:0] ofs;
      begin
         is_reg = (a == ofs);
      end
   endfunction

   // Register decodes shared by the write and read paths
   assign np_rd     = rd_stb && is_reg(reg_addr, `MMDIA_OFS_PARTNER_NP);
   assign ctl_rd    = rd_stb && is_reg(reg_addr, `MMDIA_OFS_CONTROL);
   assign ctl_wr    = wr_stb && is_reg(reg_addr, `MMDIA_OFS_CONTROL);
   assign port_rd   = rd_stb && is_reg(reg_addr, `MMDIA_OFS_PORT);
   assign port_wr   = wr_stb && is_reg(reg_addr, `MMDIA_OFS_PORT);
   assign data_mode = (mode_reg != `MMDIA_MODE_REG);
   assign ctl_word  = {mode_reg, rsvd_reg, dev_reg};

   // Only the selected device's address moves; the others hold
   always @* begin
      load = 1'b0;
      incr = 1'b0;
      case (mode_reg)
         `MMDIA_MODE_REG: begin
            load = port_wr;
         end
         `MMDIA_MODE_DATA: begin
            incr = 1'b0;
         end
         `MMDIA_MODE_INC_RW: begin
            incr = port_wr || port_rd;
         end
         `MMDIA_MODE_INC_WR: begin
            incr = port_wr;
         end
         default: begin
            // Unreachable; keeps the decode total
            incr = 1'b0;
         end
      endcase
   end

   mmdia_addr_store #(
      .DEV_W  (DEV_W),
      .DATA_W (DATA_W)
   ) u_store (
      .clock      (clock),
      .arst_n     (arst_n),
      .dev_sel    (dev_reg),
      .load       (load),
      .load_value (wr_data),
      .incr       (incr),
      .cur_addr   (cur_addr)
   );

   // Captured only on a new page so the word is stable while the host reads
   always @* begin
      np_word_next = np_word_reg;
      if (np_valid) begin
         np_word_next[`MMDIA_NP_MORE_BIT]   = np_more;
         np_word_next[`MMDIA_NP_ACK_BIT]    = np_ack;
         np_word_next[`MMDIA_NP_MSG_BIT]    = np_message;
         np_word_next[`MMDIA_NP_COMPLY_BIT] = partner_can_comply;
         np_word_next[`MMDIA_NP_TOGGLE_BIT] = ~np_prev_toggle;
         np_word_next[`MMDIA_NP_CODE_HI:`MMDIA_NP_CODE_LO] = np_code;
      end
   end

   // Page word reads zero until the first page
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         np_word_reg <= `MMDIA_RST_WORD;
      end else begin
         np_word_reg <= np_word_next;
      end
   end

   // Reserved bits kept so the host reads back what it wrote
   always @* begin
      mode_next = mode_reg;
      rsvd_next = rsvd_reg;
      dev_next  = dev_reg;
      if (ctl_wr) begin
         mode_next = wr_data[`MMDIA_CTL_MODE_HI:`MMDIA_CTL_MODE_LO];
         rsvd_next = wr_data[`MMDIA_CTL_RSVD_HI:`MMDIA_CTL_RSVD_LO];
         dev_next  = wr_data[`MMDIA_CTL_DEV_HI:`MMDIA_CTL_DEV_LO];
      end
   end

   // Reset leaves register mode on device zero
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= `MMDIA_MODE_REG;
         rsvd_reg <= `MMDIA_RST_RSVD;
         dev_reg  <= `MMDIA_RST_DEV;
      end else begin
         mode_reg <= mode_next;
         rsvd_reg <= rsvd_next;
         dev_reg  <= dev_next;
      end
   end

   // Unmapped reads return zero instead of stale data
   always @* begin
      rd_data_next = rd_data;
      if (np_rd) begin
         rd_data_next = np_word_reg;
      end else if (ctl_rd) begin
         rd_data_next = ctl_word;
      end else if (port_rd) begin
         rd_data_next = data_mode ? mmd_rdata : cur_addr;
      end else if (rd_stb) begin
         rd_data_next = `MMDIA_RST_WORD;
      end
   end

   always @* begin
      mmd_wr_next = port_wr && data_mode;
      mmd_rd_next = port_rd && data_mode;
   end

   // Store sees the address of the strobe cycle, before its increment; back-to-back accesses need no gap
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mmd_wr    <= 1'b0;
         mmd_rd    <= 1'b0;
         mmd_dev   <= `MMDIA_RST_DEV;
         mmd_addr  <= `MMDIA_RST_WORD;
         mmd_wdata <= `MMDIA_RST_WORD;
         rd_data   <= `MMDIA_RST_WORD;
      end else begin
         mmd_wr    <= mmd_wr_next;
         mmd_rd    <= mmd_rd_next;
         mmd_dev   <= dev_reg;
         mmd_addr  <= cur_addr;
         // Data forwarded every cycle; only the strobe qualifies it
         mmd_wdata <= wr_data;
         rd_data   <= rd_data_next;
      end
   end
endmodule // mmdia_regs

// *** mmdia_store_model.sv ***
// Purpose: device store behind the access window
// Assumes: one word of storage
// Notes: returns the last word written
`timescale 1ns/10ps
module mmdia_store_model (
   input  logic        clock,
   input  logic        mmd_wr,
   input  logic [15:0] mmd_wdata,
   output logic [15:0] mmd_rdata
);
   initial mmd_rdata = 16'h5A5A;
   always @(posedge clock) if (mmd_wr) mmd_rdata <= mmd_wdata;
endmodule // mmdia_store_model

// *** mmdia_regs_chk.sv ***
// Purpose: port checks of the access window
// Assumes: one strobe per cycle
// Notes: control and stored address mirrored
`timescale 1ns/10ps
module mmdia_regs_chk (
   input logic        clock,
   input logic        arst_n,
   input logic [4:0]  reg_addr,
   input logic        rd_stb,
   input logic        wr_stb,
   input logic [15:0] wr_data,
   input logic [15:0] rd_data,
   input logic        mmd_wr,
   input logic        mmd_rd,
   input logic [4:0]  mmd_dev,
   input logic [15:0] mmd_addr,
   input logic [15:0] mmd_wdata,
   input logic [15:0] mmd_rdata
);
   logic [15:0] ctl_reg, adr_reg;
   logic        inc_reg, ok_reg;
   wire         pw = wr_stb && reg_addr == 5'h0E;
   wire         dm = ctl_reg[15:14] != 2'h0;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Step check dropped when device changes
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) {ctl_reg, adr_reg, inc_reg, ok_reg} <= '0;
      else begin
         if (wr_stb && reg_addr == 5'h0D) ctl_reg <= wr_data;
         if (wr_stb && reg_addr == 5'h0D && wr_data[4:0] != ctl_reg[4:0]) ok_reg <= 1'b0;
         if (pw && !dm) {adr_reg, inc_reg, ok_reg} <= {wr_data, 2'b01};
         if (mmd_wr || mmd_rd) {adr_reg, inc_reg} <= {mmd_addr, ctl_reg[15] & (mmd_wr | ~ctl_reg[14])};
      end
   end
   wr_cause_a: assert property (mmd_wr |-> $past(pw && dm) && mmd_wdata == $past(wr_data))
      else $error("port write pulse without cause");
   rd_cause_a: assert property (mmd_rd |-> $past(rd_stb && reg_addr == 5'h0E && dm))
      else $error("port read pulse without cause");
   addr_mode_a: assert property (pw && !dm |=> !mmd_wr)
      else $error("address write reached device");
   ctl_read_a: assert property (rd_stb && reg_addr == 5'h0D |=> rd_data == $past(ctl_reg))
      else $error("control readback wrong");
   data_read_a: assert property (rd_stb && reg_addr == 5'h0E && dm |=> rd_data == $past(mmd_rdata))
      else $error("port read data wrong");
   unmapped_read_a: assert property (rd_stb && !(reg_addr inside {5'h08, 5'h0D, 5'h0E}) |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   addr_step_a: assert property ((mmd_wr || mmd_rd) && ok_reg |-> mmd_addr == adr_reg + inc_reg)
      else $error("stored address step wrong");
   dev_sel_a: assert property (mmd_wr || mmd_rd |-> mmd_dev == ctl_reg[4:0])
      else $error("device select wrong");
endmodule // mmdia_regs_chk

// *** mmdia_regs_test.sv ***
// Purpose: self-checking bench of the access window
// Assumes: 20 MHz clock, store model on the port
// Notes: rows are {write, reg, data}; reads compare data
`timescale 1ns/10ps
module mmdia_regs_test;
   logic        clock, arst_n, rd_stb, wr_stb, np_valid, np_more, np_ack, np_message;
   logic        partner_can_comply, np_prev_toggle, mmd_wr, mmd_rd;
   logic [4:0]  reg_addr, mmd_dev;
   logic [10:0] np_code;
   logic [15:0] wr_data, rd_data, mmd_addr, mmd_wdata, mmd_rdata;
   int          n_fail = 0, n_tests = 0, cyc = 0;
   logic [21:0] rows [0:21] = '{22'h0D0000, 22'h0E0000, 22'h2D0003, 22'h2E0010, 22'h0E0010, 22'h2D4003,
      22'h2E1234, 22'h2E5678, 22'h0E5678, 22'h2D8003, 22'h2EAAAA, 22'h0EAAAA, 22'h2DC003, 22'h2EC3C3,
      22'h0EC3C3, 22'h0EC3C3, 22'h2D3FE3, 22'h0E0013, 22'h0D3FE3, 22'h28FFFF, 22'h080000, 22'h050000};
   mmdia_regs u_dut (.clock, .arst_n, .reg_addr, .rd_stb, .wr_stb, .wr_data, .rd_data, .np_valid, .np_more,
      .np_ack, .np_message, .partner_can_comply, .np_prev_toggle, .np_code, .mmd_wr, .mmd_rd, .mmd_dev,
      .mmd_addr, .mmd_wdata, .mmd_rdata);
   mmdia_store_model u_store (.clock, .mmd_wr, .mmd_wdata, .mmd_rdata);
   task stop_test;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      {wr_stb, rd_stb, reg_addr, wr_data} <= {w, !w, a, d};
      @(posedge clock);
      {wr_stb, rd_stb} <= 2'b00;
      #1;
   endtask
   task page(input logic [4:0] f, input logic [10:0] c, input logic [15:0] e);
      @(posedge clock);
      {np_more, np_ack, np_message, partner_can_comply, np_prev_toggle, np_code, np_valid} <= {f, c, 1'b1};
      @(posedge clock);
      np_valid <= 1'b0;
      acc(1'b0, 5'h08, 16'h0000);
      chk(rd_data, e);
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Hang guard, run needs under 100 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 400) begin
         n_fail++;
         stop_test;
      end
   end
   initial begin
      {rd_stb, wr_stb, reg_addr, wr_data, np_valid, np_more, np_ack, np_message} = '0;
      {partner_can_comply, np_prev_toggle, np_code, arst_n} = '0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         acc(rows[i][21], rows[i][20:16], rows[i][15:0]);
         if (!rows[i][21]) chk(rd_data, rows[i][15:0]);
      end
      $display("table done");
      page(5'h14, 11'h7FF, 16'hAFFF);
      page(5'h0B, 11'h001, 16'h5001);
      $display("page done");
      @(posedge clock);
      arst_n <= 1'b0;
      @(posedge clock);
      arst_n <= 1'b1;
      acc(1'b0, 5'h0D, 16'h0000);
      chk(rd_data, 16'h0000);
      acc(1'b0, 5'h08, 16'h0000);
      chk(rd_data, 16'h0000);
      $display("reset done");
      stop_test;
   end
endmodule // mmdia_regs_test
bind mmdia_regs mmdia_regs_chk u_chk (.clock, .arst_n, .reg_addr, .rd_stb, .wr_stb, .wr_data, .rd_data,
   .mmd_wr, .mmd_rd, .mmd_dev, .mmd_addr, .mmd_wdata, .mmd_rdata);
